/* File: ssc_pkg.sv */
/*
 * Shared constants and carriers for the self-test change detector block.
 * Assumes a 250 MHz APB clock and 8-bit registers, one per aligned word.
 */
`default_nettype none
package ssc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_X_LO    = 8'h04;
	localparam logic [7:0] IDX_X_HI    = 8'h05;
	localparam logic [7:0] IDX_Y_LO    = 8'h06;
	localparam logic [7:0] IDX_Y_HI    = 8'h07;
	localparam logic [7:0] IDX_Z_LO    = 8'h08;
	localparam logic [7:0] IDX_Z_HI    = 8'h09;
	localparam logic [7:0] IDX_MAIN    = 8'h15;
	localparam logic [7:0] IDX_FOURTH  = 8'h18;
	localparam logic [7:0] IDX_IRQ_EN  = 8'h20;
	localparam logic [7:0] IDX_ROUTE   = 8'h21;
	localparam logic [7:0] IDX_AXIS    = 8'h2f;
	localparam logic [7:0] IDX_MODE    = 8'h30;
	localparam logic [7:0] IDX_LTH_LO  = 8'h33;
	localparam logic [7:0] IDX_LTH_HI  = 8'h34;
	localparam logic [7:0] IDX_UTH_LO  = 8'h35;
	localparam logic [7:0] IDX_UTH_HI  = 8'h36;
	localparam logic [7:0] IDX_RATE    = 8'h38;
	localparam logic [7:0] REG_RESET   = 8'h00;
	// Main configuration fields
	localparam int MAIN_ACTIVE  = 0;
	localparam int MAIN_FSR_LO  = 1;
	localparam int MAIN_POL     = 5;
	localparam int MAIN_AXIS_LO = 6;
	localparam logic [1:0] AXIS_OFF = 2'b00;
	localparam logic [1:0] AXIS_X   = 2'b01;
	localparam logic [1:0] AXIS_Y   = 2'b10;
	localparam logic [1:0] AXIS_Z   = 2'b11;
	localparam logic [1:0] FSR_16G  = 2'b11;
	// Other fields
	localparam int FOURTH_PULSE = 0;
	localparam int IRQ_DATA_READY_EVENT     = 7;
	localparam int IRQ_OUTSIDE  = 5;
	localparam int ROUTE_DATA_READY_EVENT   = 0;
	localparam int ROUTE_OUT    = 2;
	localparam int AXIS_X_EN    = 7;
	localparam int AXIS_Y_EN    = 6;
	localparam int AXIS_Z_EN    = 5;
	localparam int MODE_ON      = 7;
	localparam int MODE_REF_LO  = 5;
	localparam int MODE_DBC     = 4;
	localparam logic [1:0] REF_ABSOLUTE = 2'b11;
	// Data-ready pulse width
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned DATA_READY_EVENT_PULSE_US  = 32;
	localparam int unsigned DATA_READY_EVENT_PULSE_CYC = DATA_READY_EVENT_PULSE_US * CLK_MHZ;
	localparam int unsigned PULSE_CNT_W    = 16;

	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} ssc_sample_s;

	typedef struct packed {
		logic [2:0] axis_on;
		logic       negative;
		logic [1:0] range;
		logic       active;
	} ssc_stim_s;
endpackage
`default_nettype wire

/* File: ssc_pulse_timer.sv */
/*
 * One-shot timer that holds busy for a fixed count of clocks.
 * Assumes start and kill are single-clock synchronous strobes.
 */
`default_nettype none
module ssc_pulse_timer #(
	parameter int unsigned CYCLES = ssc_pkg::DATA_READY_EVENT_PULSE_CYC
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic start,
	input  wire logic kill,
	// Status
	output logic      busy
);
	import ssc_pkg::*;
	logic [PULSE_CNT_W-1:0] count;
	wire                    last = (count == PULSE_CNT_W'(CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy  <= 1'b0;
			count <= '0;
		end else if (start) begin
			busy  <= 1'b1;
			count <= '0;
		end else if (kill) begin
			busy  <= 1'b0;
			count <= '0;
		end else if (busy) begin
			busy  <= !last;
			count <= count + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: ssc_window_cmp.sv */
/*
 * Signed window comparator for one axis of the change detector.
 * Assumes lower and upper are given in the same counts as the value.
 */
`default_nettype none
module ssc_window_cmp (
	// Operands
	input  wire logic signed [15:0] value,
	input  wire logic signed [15:0] lower,
	input  wire logic signed [15:0] upper,
	// Result
	output logic                    outside
);
	assign outside = (value < lower) || (value > upper);
endmodule
`default_nettype wire

/* File: ssc_selftest_detect.sv */
/*
 * Accelerometer register block with self-test stimulus control, data-ready
 * signalling and the outside-thresholds change detector, behind APB.
 * Assumes raw samples arrive synchronous to pclk with a one-cycle valid.
 */
`default_nettype none
// What this block does
// - Data-ready enable drives line one by default; line two also selectable.
// - In pulse mode data-ready drops alone 32 us after rising.
// - Axis select 01 drives X, 10 Y, 11 Z; 00 disables stimulus.
// - Polarity zero gives positive stimulus, one gives negative.
// - Range field 11 selects the 16 g range.
// - X, Y, Z data sit at 04h/05h, 06h/07h, 08h/09h.
// - Lower threshold at 33h/34h, upper at 35h/36h, low byte first.
// - Enable with reference mode 11 is absolute; debounce mode bit stored.
// - Motion event can come only from the second sample after activation.
// - Enable bit 7 is data-ready, bit 5 outside; both reset disabled.
module ssc_selftest_detect #(
	parameter int unsigned PULSE_CYC = ssc_pkg::DATA_READY_EVENT_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	// Sensor front end
	input  wire ssc_pkg::ssc_sample_s raw,
	input  wire logic                raw_valid,
	output ssc_pkg::ssc_stim_s       stim,
	// Interrupt lines
	output logic                     int_line_one,
	output logic                     int_line_two
);
	import ssc_pkg::*;

	function automatic logic signed [15:0] word16(input logic [7:0] hi, input logic [7:0] lo);
		word16 = {hi, lo};
	endfunction

	// Register storage
	logic [7:0]         main_cfg, fourth_cfg, irq_en, route_cfg, axis_cfg, mode_cfg;
	logic [7:0]         lth_lo, lth_hi, uth_lo, uth_hi, rate_cfg;
	logic signed [15:0] data_x, data_y, data_z;

	// Bus decode
	wire [7:0] idx      = {2'b00, paddr[7:2]};
	wire       setup    = psel && !penable;
	wire       access   = psel && penable;
	wire       hit_main = (idx == IDX_MAIN);
	wire       hit_data = (idx >= IDX_X_LO) && (idx <= IDX_Z_HI);
	wire       hit_rw   = hit_main || (idx == IDX_FOURTH) || (idx == IDX_IRQ_EN)
		|| (idx == IDX_ROUTE) || (idx == IDX_AXIS) || (idx == IDX_MODE)
		|| ((idx >= IDX_LTH_LO) && (idx <= IDX_UTH_HI)) || (idx == IDX_RATE);
	wire       mapped   = hit_rw || hit_data;
	wire       wr       = access && pwrite && hit_rw;
	wire       wr_main  = wr && hit_main;
	wire       rd_data  = access && !pwrite && hit_data;
	logic [7:0] rd_mux;

	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	always_comb begin
		case (idx)
			IDX_X_LO:   rd_mux = data_x[7:0];
			IDX_X_HI:   rd_mux = data_x[15:8];
			IDX_Y_LO:   rd_mux = data_y[7:0];
			IDX_Y_HI:   rd_mux = data_y[15:8];
			IDX_Z_LO:   rd_mux = data_z[7:0];
			IDX_Z_HI:   rd_mux = data_z[15:8];
			IDX_MAIN:   rd_mux = main_cfg;
			IDX_FOURTH: rd_mux = fourth_cfg;
			IDX_IRQ_EN: rd_mux = irq_en;
			IDX_ROUTE:  rd_mux = route_cfg;
			IDX_AXIS:   rd_mux = axis_cfg;
			IDX_MODE:   rd_mux = mode_cfg;
			IDX_LTH_LO: rd_mux = lth_lo;
			IDX_LTH_HI: rd_mux = lth_hi;
			IDX_UTH_LO: rd_mux = uth_lo;
			IDX_UTH_HI: rd_mux = uth_hi;
			IDX_RATE:   rd_mux = rate_cfg;
			default:    rd_mux = 8'h00;
		endcase
	end

	// Read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= {24'h00_0000, rd_mux};
	end

	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_cfg   <= REG_RESET;
			fourth_cfg <= REG_RESET;
			irq_en     <= REG_RESET;
			route_cfg  <= REG_RESET;
			axis_cfg   <= REG_RESET;
			mode_cfg   <= REG_RESET;
			lth_lo     <= REG_RESET;
			lth_hi     <= REG_RESET;
			uth_lo     <= REG_RESET;
			uth_hi     <= REG_RESET;
			rate_cfg   <= REG_RESET;
		end else if (wr) begin
			case (idx)
				IDX_MAIN:   main_cfg   <= pwdata[7:0];
				IDX_FOURTH: fourth_cfg <= pwdata[7:0];
				IDX_IRQ_EN: irq_en     <= pwdata[7:0];
				IDX_ROUTE:  route_cfg  <= pwdata[7:0];
				IDX_AXIS:   axis_cfg   <= pwdata[7:0];
				IDX_MODE:   mode_cfg   <= pwdata[7:0];
				IDX_LTH_LO: lth_lo     <= pwdata[7:0];
				IDX_LTH_HI: lth_hi     <= pwdata[7:0];
				IDX_UTH_LO: uth_lo     <= pwdata[7:0];
				IDX_UTH_HI: uth_hi     <= pwdata[7:0];
				IDX_RATE:   rate_cfg   <= pwdata[7:0];
				default:    rate_cfg   <= rate_cfg;
			endcase
		end
	end

	// Stimulus and range
	wire       active     = main_cfg[MAIN_ACTIVE];
	wire [1:0] axis_sel   = main_cfg[MAIN_AXIS_LO +: 2];
	wire       st_on      = (axis_sel != AXIS_OFF);
	wire [2:0] next_axis  = (axis_sel == AXIS_X) ? 3'b001 :
		(axis_sel == AXIS_Y) ? 3'b010 : (axis_sel == AXIS_Z) ? 3'b100 : 3'b000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stim <= '0;
		end else begin
			stim.axis_on  <= next_axis;
			stim.negative <= st_on && main_cfg[MAIN_POL];
			stim.range    <= main_cfg[MAIN_FSR_LO +: 2];
			stim.active   <= active;
		end
	end

	// Output sampling with self-test decimation
	logic       active_d;
	logic [7:0] dec_cnt;
	logic [1:0] samp_cnt;
	logic       new_sample;
	wire        act_rise = active && !active_d;
	wire        dec_hit  = !st_on || (dec_cnt >= rate_cfg);
	wire        take     = active && !act_rise && raw_valid && dec_hit;
	wire        settled  = (samp_cnt != 2'd0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_d   <= 1'b0;
			dec_cnt    <= 8'h00;
			samp_cnt   <= 2'd0;
			new_sample <= 1'b0;
			data_x     <= '0;
			data_y     <= '0;
			data_z     <= '0;
		end else begin
			active_d   <= active;
			new_sample <= take;
			if (act_rise) begin
				dec_cnt  <= 8'h00;
				samp_cnt <= 2'd0;
			end else if (active && raw_valid) begin
				dec_cnt <= dec_hit ? 8'h00 : dec_cnt + 8'h01;
				if (take && samp_cnt != 2'd3)
					samp_cnt <= samp_cnt + 2'd1;
			end
			if (take) begin
				data_x <= raw.x;
				data_y <= raw.y;
				data_z <= raw.z;
			end
		end
	end

	// Data-ready: pulse or sticky level
	logic data_ready_event_lvl;
	logic data_ready_event_pulse;
	wire  pulse_opt = fourth_cfg[FOURTH_PULSE];
	wire  data_ready_event_out  = pulse_opt ? data_ready_event_pulse : data_ready_event_lvl;

	ssc_pulse_timer #(
		.CYCLES (PULSE_CYC)
	) u_data_ready_event_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (new_sample && pulse_opt),
		.kill    (wr_main),
		.busy    (data_ready_event_pulse)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_ready_event_lvl <= 1'b0;
		else if (new_sample && !pulse_opt)
			data_ready_event_lvl <= 1'b1;
		else if (rd_data || wr_main || pulse_opt)
			data_ready_event_lvl <= 1'b0;
	end

	// Change detector
	wire signed [15:0] lower    = word16(lth_hi, lth_lo);
	wire signed [15:0] upper    = word16(uth_hi, uth_lo);
	wire               abs_mode = (mode_cfg[MODE_REF_LO +: 2] == REF_ABSOLUTE);
	wire        [2:0]  ax_en    = {axis_cfg[AXIS_Z_EN], axis_cfg[AXIS_Y_EN],
		axis_cfg[AXIS_X_EN]};
	wire signed [15:0] cur [3];
	wire signed [15:0] prev [3];
	wire        [2:0]  out_axis;
	logic              mot_lvl;

	assign cur[0]  = raw.x;
	assign cur[1]  = raw.y;
	assign cur[2]  = raw.z;
	assign prev[0] = data_x;
	assign prev[1] = data_y;
	assign prev[2] = data_z;

	for (genvar a = 0; a < 3; a++) begin : g_axis
		ssc_window_cmp u_cmp (
			.value   (abs_mode ? cur[a] : 16'(cur[a] - prev[a])),
			.lower   (lower),
			.upper   (upper),
			.outside (out_axis[a])
		);
	end

	wire det_on   = mode_cfg[MODE_ON] && active;
	wire mot_hit  = take && settled && det_on && |(out_axis & ax_en);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mot_lvl <= 1'b0;
		else if (mot_hit)
			mot_lvl <= 1'b1;
		else if (wr_main)
			mot_lvl <= 1'b0;
	end

	// Interrupt routing
	wire data_ready_event_irq = data_ready_event_out && irq_en[IRQ_DATA_READY_EVENT];
	wire ot_irq   = mot_lvl && irq_en[IRQ_OUTSIDE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_line_one <= 1'b0;
			int_line_two <= 1'b0;
		end else begin
			int_line_one <= (data_ready_event_irq && !route_cfg[ROUTE_DATA_READY_EVENT])
				|| (ot_irq && !route_cfg[ROUTE_OUT]);
			int_line_two <= (data_ready_event_irq && route_cfg[ROUTE_DATA_READY_EVENT])
				|| (ot_irq && route_cfg[ROUTE_OUT]);
		end
	end

	// Checks
	logic [PULSE_CNT_W-1:0] pulse_len;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pulse_len <= '0;
		else
			pulse_len <= data_ready_event_pulse ? pulse_len + 1'b1 : '0;
	end

	pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
		data_ready_event_pulse |-> pulse_len < PULSE_CNT_W'(PULSE_CYC))
		else $error("data-ready pulse too long");
	pulse_full_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(data_ready_event_pulse) && !wr_main ##1 !wr_main [*2] |-> data_ready_event_pulse)
		else $error("data-ready pulse ended early");
	axis_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(axis_sel == AXIS_Y) |=> stim.axis_on == 3'b010 || $past(wr_main))
		else $error("stimulus axis wrong");
	polarity_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(axis_sel == AXIS_OFF) |=> !stim.negative || $past(wr_main))
		else $error("stimulus without axis");
	range_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(main_cfg[MAIN_FSR_LO +: 2]) == FSR_16G |-> stim.range == FSR_16G)
		else $error("range not forwarded");
	data_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && idx == IDX_Y_HI && !take |=> prdata[7:0] == data_y[15:8])
		else $error("y high byte read wrong");
	first_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && samp_cnt == 2'd0 && !mot_lvl |=> !mot_lvl)
		else $error("motion on first sample");
	irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(irq_en[IRQ_DATA_READY_EVENT]) == 1'b0 && $past(irq_en[IRQ_OUTSIDE]) == 1'b0
		|-> !int_line_one && !int_line_two)
		else $error("interrupt while disabled");
	line_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		data_ready_event_irq && route_cfg == 8'h00 |=> int_line_one)
		else $error("data-ready missing on line one");
	window_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mot_lvl) |-> $past(det_on) && $past(|(out_axis & ax_en)))
		else $error("motion without outside sample");

	pulse_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(data_ready_event_pulse) && !$past(wr_main));
	motion_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(mot_lvl) && stim.negative);
	line_two_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(int_line_two));
endmodule
`default_nettype wire

/* File: ssc_sensor_model.sv */
/*
 * Behavioural model of the sensor front end: a raw sample every PERIOD clocks,
 * shifted by a fixed stimulus step on each axis that the stimulus selects.
 * Assumes the stimulus struct of the block under test and one pclk domain.
 */
`default_nettype none
module ssc_sensor_model #(
	parameter int                 PERIOD = 10,
	parameter logic signed [15:0] BASE_X = 16'sd17,
	parameter logic signed [15:0] BASE_Y = -16'sd6,
	parameter logic signed [15:0] BASE_Z = 16'sd125,
	parameter logic signed [15:0] DELTA  = 16'sd115
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// Stimulus from the block
	input  wire ssc_pkg::ssc_stim_s   stim,
	// Samples to the block
	output ssc_pkg::ssc_sample_s      raw,
	output logic                      raw_valid
);
	import ssc_pkg::*;
	int                 cnt;
	wire logic          last = (cnt == PERIOD - 1);
	wire logic signed [15:0] push = stim.negative ? -DELTA : DELTA;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt       <= 0;
			raw_valid <= 1'b0;
			raw       <= '0;
		end else begin
			cnt       <= last ? 0 : cnt + 1;
			raw_valid <= last;
			// Outside the valid cycle the lines show junk
			raw.x <= last ? BASE_X + (stim.axis_on[0] ? push : 16'sd0) : ~raw.x;
			raw.y <= last ? BASE_Y + (stim.axis_on[1] ? push : 16'sd0) : ~raw.y;
			raw.z <= last ? BASE_Z + (stim.axis_on[2] ? push : 16'sd0) : ~raw.z;
		end
	end
endmodule
`default_nettype wire

/* File: ssc_selftest_detect_tb.sv */
/*
 * Testbench: a host over APB runs the self-test validation sequence per axis.
 * Assumes the sensor model as front end and a shortened data-ready pulse.
 */
`default_nettype none
module ssc_selftest_detect_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ssc_pkg::*;
	localparam int                 PULSE = 20;
	localparam logic signed [15:0] BASE [3] = '{16'sd17, -16'sd6, 16'sd125};
	localparam logic signed [15:0] DELTA = 16'sd115;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = '0;
	logic [31:0]        pwdata = '0;
	logic               pready;
	logic               pslverr;
	logic [31:0]        prdata;
	logic               int_line_one;
	logic               int_line_two;
	logic               raw_valid;
	ssc_sample_s        raw;
	ssc_stim_s          stim;
	int                 err_count = 0;
	int                 comparisons = 0;
	always #2 pclk = ~pclk;

	ssc_selftest_detect #(.PULSE_CYC(PULSE)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .raw(raw),
		.raw_valid(raw_valid), .stim(stim), .int_line_one(int_line_one),
		.int_line_two(int_line_two));
	ssc_sensor_model #(.BASE_X(BASE[0]), .BASE_Y(BASE[1]), .BASE_Z(BASE[2]),
		.DELTA(DELTA)) sensor (.pclk(pclk), .presetn(presetn), .stim(stim),
		.raw(raw), .raw_valid(raw_valid));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx[5:0], 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			tally_and_finish;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] r);
		logic e;
		apb(1'b0, idx, 8'h00, r, e);
	endtask
	task automatic wchk(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		wr(idx, d);
		rd(idx, r);
		check(r, {24'h0, d});
	endtask
	function automatic logic line(input logic two);
		return two ? int_line_two : int_line_one;
	endfunction
	task automatic wait_level(input logic two, input logic lvl);
		int n;
		n = 0;
		while (line(two) !== lvl && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			tally_and_finish;
		end
	endtask
	task automatic wait_rise(input logic two);
		wait_level(two, 1'b0);
		wait_level(two, 1'b1);
	endtask

	initial begin
		logic [31:0]        r;
		logic [31:0]        lo;
		logic [31:0]        hi;
		logic [31:0]        thr;
		logic               e;
		logic [7:0]         cfg;
		logic signed [15:0] v;
		int                 smp [2];
		int                 w;
		int                 n;
		int                 off;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_IRQ_EN, r);
		check(r, 32'h0);
		check(32'(stim), 32'h0);
		apb(1'b0, 8'h3f, 8'h00, r, e);
		check(e, 1'b1);
		check(r, 32'h0);
		for (int a = 0; a < 3; a++) begin
			w = (a == 2) ? 16 : 32;
			wr(IDX_MAIN, 8'h06);
			wr(IDX_RATE, 8'h04);
			wr(IDX_IRQ_EN, 8'h80);
			wr(IDX_ROUTE, 8'h00);
			wr(IDX_FOURTH, 8'h01);
			for (int p = 0; p < 2; p++) begin
				cfg = {2'(a + 1), p[0], 4'b0011, 1'b1};
				wr(IDX_MAIN, cfg);
				repeat (2) @(negedge pclk);
				check(32'(stim.axis_on), 32'(3'b001 << a));
				check(stim.negative, p[0]);
				check(stim.range, FSR_16G);
				// First data-ready is left alone and must drop by itself
				wait_rise(1'b0);
				n = 0;
				while (int_line_one === 1'b1 && n < 1000) begin
					@(negedge pclk);
					n++;
				end
				check(n, PULSE);
				wait_rise(1'b0);
				wr(IDX_MAIN, cfg & 8'hfe);
				rd(8'(IDX_X_LO + 2 * a), lo);
				rd(8'(IDX_X_LO + 2 * a + 1), hi);
				v = {hi[7:0], lo[7:0]};
				smp[p] = v;
				check(32'(smp[p]), 32'(BASE[a] + (p ? -DELTA : DELTA)));
				wr(8'(IDX_X_LO + 2 * a), ~lo[7:0]);
				rd(8'(IDX_X_LO + 2 * a), r);
				check(r, lo);
			end
			check((smp[0] - smp[1]) / 2 > w, 1'b1);
			off = (smp[0] + smp[1]) / 2;
			thr = {16'(off + w), 16'(off - w)};
			for (int i = 0; i < 4; i++)
				wchk(8'(IDX_LTH_LO + i), thr[8 * i +: 8]);
			wchk(IDX_AXIS, 8'h80 >> a);
			wchk(IDX_MODE, 8'hf0);
			wchk(IDX_IRQ_EN, 8'ha0);
			// Data-ready moved to line two; motion stays on line one
			wr(IDX_ROUTE, 8'h01);
			for (int p = 0; p < 2; p++) begin
				cfg = {2'(a + 1), p[0], 4'b0011, 1'b1};
				wr(IDX_MAIN, cfg);
				n = 0;
				while (int_line_one !== 1'b1 && n < 3000) begin
					@(negedge pclk);
					n++;
				end
				if (n >= 3000) begin
					err_count++;
					tally_and_finish;
				end
				// First kept sample lands near 50 cycles, the second near 100
				check(n > 60 && n < 120, 1'b1);
				check(int_line_two, 1'b0);
				wr(IDX_MAIN, cfg & 8'hfe);
				repeat (2) @(negedge pclk);
				check(int_line_one, 1'b0);
			end
			wr(IDX_MAIN, 8'h06);
			wr(IDX_MAIN, 8'h07);
			repeat (2) @(negedge pclk);
			check(32'(stim.axis_on), 32'h0);
			check(stim.active, 1'b1);
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
